// ===== rtl/lcdw_top.v
`timescale 1ns/1ps
`include "lcdw_regs.vh"

module lcdw_top #(
  parameter COLS     = `LCDW_NUM_COLS,
  parameter ROW_HOLD = `LCDW_ROW_HOLD
) (
  input  wire            ref_clk,
  input  wire            rst,
  input  wire            mode_set,
  input  wire [1:0]      mode_value,
  input  wire            ptr_load,
  input  wire [5:0]      ptr_value,
  input  wire            dev_select,
  input  wire [2:0]      dev_value,
  input  wire            bank_select,
  input  wire            bank_in_value,
  input  wire            bank_out_value,
  input  wire            data_valid,
  input  wire [7:0]      data_byte,
  input  wire            strap_subaddr_bit0,
  input  wire            strap_subaddr_bit1,
  input  wire            strap_subaddr_bit2,
  output reg             busy,
  output reg             byte_ack,
  output reg             byte_nack,
  output reg  [1:0]      drive_mode,
  output reg  [5:0]      data_ptr,
  output reg  [2:0]      sub_cnt,
  output reg             in_bank,
  output reg             out_bank,
  output reg             backplane_out_0,
  output reg             backplane_out_1,
  output reg             backplane_out_2,
  output reg             backplane_out_3,
  output wire [COLS-1:0] segment_outputs
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_WRITE = 1'b1;
  localparam [4:0] HOLD_LAST = ROW_HOLD - 1;

  reg        state;
  reg [1:0]  word_mode;
  reg        word_bank;
  reg [7:0]  shreg;
  reg [3:0]  words_left;
  reg        stored_any;
  reg [4:0]  hold_cnt;
  reg [1:0]  phase;

  reg [3:0]  next_words;
  reg [2:0]  shift_bits;
  reg [3:0]  wr_data;
  reg [3:0]  wr_mask;
  reg [1:0]  last_phase;
  reg [1:0]  rd_row;

  wire [2:0] strap_addr;
  wire       addr_match;
  wire       in_range;
  wire       wr_en;
  wire       last_word;
  wire       overflow;

  assign strap_addr = {strap_subaddr_bit2, strap_subaddr_bit1,
                       strap_subaddr_bit0};
  // Strap is sampled directly; it must not move during an access
  assign addr_match = (sub_cnt == strap_addr);
  assign in_range   = (data_ptr <= `LCDW_LAST_COL);
  assign wr_en      = (state == ST_WRITE) && addr_match && in_range;
  assign last_word  = (words_left == 4'd1);
  assign overflow   = (data_ptr >= `LCDW_LAST_COL);

  // Words per byte equal the columns advanced per byte
  always @* begin
    case (drive_mode)
      `LCDW_MODE_STATIC: next_words = `LCDW_WORDS_STATIC;
      `LCDW_MODE_TWO:    next_words = `LCDW_WORDS_TWO;
      `LCDW_MODE_THREE:  next_words = `LCDW_WORDS_THREE;
      default:           next_words = `LCDW_WORDS_FOUR;
    endcase
  end

  // Word shaping: msb first, rows by mode and input bank
  always @* begin
    wr_data    = 4'h0;
    wr_mask    = 4'h0;
    shift_bits = `LCDW_BITS_FOUR;
    case (word_mode)
      `LCDW_MODE_STATIC: begin
        shift_bits = `LCDW_BITS_STATIC;
        if (word_bank) begin
          wr_data = {1'b0, shreg[7], 2'b00};
          wr_mask = 4'b0100;
        end else begin
          wr_data = {3'b000, shreg[7]};
          wr_mask = 4'b0001;
        end
      end
      `LCDW_MODE_TWO: begin
        shift_bits = `LCDW_BITS_TWO;
        if (word_bank) begin
          wr_data = {shreg[6], shreg[7], 2'b00};
          wr_mask = 4'b1100;
        end else begin
          wr_data = {2'b00, shreg[6], shreg[7]};
          wr_mask = 4'b0011;
        end
      end
      `LCDW_MODE_THREE: begin
        shift_bits = `LCDW_BITS_THREE;
        wr_data    = {1'b0, shreg[5], shreg[6], shreg[7]};
        // Third word carries only two bits; row 2 there is left alone
        wr_mask    = last_word ? 4'b0011 : 4'b0111;
      end
      default: begin
        shift_bits = `LCDW_BITS_FOUR;
        wr_data    = {shreg[4], shreg[5], shreg[6], shreg[7]};
        wr_mask    = 4'b1111;
      end
    endcase
  end

  // Configuration and the byte writer
  always @(posedge ref_clk) begin
    if (rst) begin
      state      <= ST_IDLE;
      drive_mode <= `LCDW_MODE_RESET;
      in_bank    <= 1'b0;
      out_bank   <= 1'b0;
      data_ptr   <= `LCDW_PTR_RESET;
      sub_cnt    <= `LCDW_SUB_RESET;
      word_mode  <= `LCDW_MODE_RESET;
      word_bank  <= 1'b0;
      shreg      <= 8'h00;
      words_left <= 4'h0;
      stored_any <= 1'b0;
      busy       <= 1'b0;
      byte_ack   <= 1'b0;
      byte_nack  <= 1'b0;
    end else begin
      byte_ack  <= 1'b0;
      byte_nack <= 1'b0;
      // Bank choices are kept apart so one bank fills while the other shows
      if (bank_select) begin
        in_bank  <= bank_in_value;
        out_bank <= bank_out_value;
      end
      case (state)
        ST_IDLE: begin
          // Commands win over a data byte offered in the same cycle
          if (mode_set || ptr_load || dev_select) begin
            if (mode_set) begin
              drive_mode <= mode_value;
            end
            if (ptr_load) begin
              data_ptr <= ptr_value;
            end
            if (dev_select) begin
              sub_cnt <= dev_value;
            end
          end else if (data_valid) begin
            // Mode and bank latched per byte so a late change cannot split it
            shreg      <= data_byte;
            word_mode  <= drive_mode;
            word_bank  <= in_bank && ((drive_mode == `LCDW_MODE_STATIC) ||
                          (drive_mode == `LCDW_MODE_TWO));
            words_left <= next_words;
            stored_any <= 1'b0;
            busy       <= 1'b1;
            state      <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          shreg      <= shreg << shift_bits;
          words_left <= words_left - 4'd1;
          // One column per word, written or not
          if (overflow) begin
            data_ptr <= `LCDW_PTR_RESET;
            sub_cnt  <= sub_cnt + 3'd1;
          end else begin
            data_ptr <= data_ptr + 6'd1;
          end
          if (wr_en) begin
            stored_any <= 1'b1;
          end
          if (last_word) begin
            // Only words this device stored count toward its acknowledge
            byte_ack  <= stored_any || wr_en;
            byte_nack <= !(stored_any || wr_en);
            busy      <= 1'b0;
            state     <= ST_IDLE;
          end
        end
        default: begin
          busy  <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Multiplex sequence length by mode
  always @* begin
    case (drive_mode)
      `LCDW_MODE_STATIC: last_phase = `LCDW_PH_STATIC;
      `LCDW_MODE_TWO:    last_phase = `LCDW_PH_TWO;
      `LCDW_MODE_THREE:  last_phase = `LCDW_PH_THREE;
      default:           last_phase = `LCDW_PH_FOUR;
    endcase
  end

  // Physical row shown for the current phase
  always @* begin
    rd_row = phase;
    if (out_bank && ((drive_mode == `LCDW_MODE_STATIC) ||
        (drive_mode == `LCDW_MODE_TWO))) begin
      rd_row = phase + `LCDW_BANK_OFS;
    end
  end

  // Row scan; backplane flags register in step with the RAM row read
  always @(posedge ref_clk) begin
    if (rst) begin
      hold_cnt        <= 5'd0;
      phase           <= 2'd0;
      backplane_out_0 <= 1'b0;
      backplane_out_1 <= 1'b0;
      backplane_out_2 <= 1'b0;
      backplane_out_3 <= 1'b0;
    end else begin
      if (hold_cnt >= HOLD_LAST) begin
        hold_cnt <= 5'd0;
        // A mode change that shortens the sequence restarts it at row 0
        if (phase >= last_phase) begin
          phase <= 2'd0;
        end else begin
          phase <= phase + 2'd1;
        end
      end else begin
        hold_cnt <= hold_cnt + 5'd1;
      end
      backplane_out_0 <= (phase == 2'd0);
      backplane_out_1 <= (phase == 2'd1);
      backplane_out_2 <= (phase == 2'd2);
      backplane_out_3 <= (phase == 2'd3);
    end
  end

  // RAM bits pass to the segments unchanged: 1 is on, 0 is off
  lcdw_ram #(
    .COLS    (COLS)
  ) u_ram (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_en),
    .wr_col  (data_ptr),
    .wr_data (wr_data),
    .wr_mask (wr_mask),
    .rd_row  (rd_row),
    .rd_data (segment_outputs)
  );

endmodule

// ===== rtl/lcdw_regs.vh
`ifndef LCDW_REGS_VH
`define LCDW_REGS_VH

// Drive mode field encodings
`define LCDW_MODE_FOUR      2'b00
`define LCDW_MODE_STATIC    2'b01
`define LCDW_MODE_TWO       2'b10
`define LCDW_MODE_THREE     2'b11
`define LCDW_MODE_RESET     2'b00

// RAM geometry
`define LCDW_NUM_COLS       40
`define LCDW_LAST_COL       6'd39
`define LCDW_COL_W          6
`define LCDW_ROWS           4

// Words per byte and pointer advance per mode
`define LCDW_WORDS_STATIC   4'd8
`define LCDW_WORDS_TWO      4'd4
`define LCDW_WORDS_THREE    4'd3
`define LCDW_WORDS_FOUR     4'd2

// Bits per word per mode
`define LCDW_BITS_STATIC    3'd1
`define LCDW_BITS_TWO       3'd2
`define LCDW_BITS_THREE     3'd3
`define LCDW_BITS_FOUR      3'd4

// Last phase of the multiplex sequence per mode
`define LCDW_PH_STATIC      2'd0
`define LCDW_PH_TWO         2'd1
`define LCDW_PH_THREE       2'd2
`define LCDW_PH_FOUR        2'd3

// Alternate bank row offset
`define LCDW_BANK_OFS       2'd2

// Row hold time: one frame divider step of 24 ref_clk cycles
`define LCDW_ROW_HOLD       24

// Reset values
`define LCDW_PTR_RESET      6'h00
`define LCDW_SUB_RESET      3'h0

`endif

// ===== rtl/lcdw_ram.v
`timescale 1ns/1ps
`include "lcdw_regs.vh"

module lcdw_ram #(
  parameter COLS = `LCDW_NUM_COLS
) (
  input  wire                   ref_clk,
  input  wire                   rst,
  input  wire                   wr_en,
  input  wire [`LCDW_COL_W-1:0] wr_col,
  input  wire [3:0]             wr_data,
  input  wire [3:0]             wr_mask,
  input  wire [1:0]             rd_row,
  output reg  [COLS-1:0]        rd_data
);

  reg [3:0] mem [0:COLS-1];
  integer   i;
  integer   k;
  integer   j;

  // Rows not in the mask keep their old bits
  always @(posedge ref_clk) begin
    if (rst) begin
      for (i = 0; i < COLS; i = i + 1) begin
        mem[i] <= 4'h0;
      end
    end else if (wr_en) begin
      for (k = 0; k < 4; k = k + 1) begin
        if (wr_mask[k]) begin
          mem[wr_col][k] <= wr_data[k];
        end
      end
    end
  end

  // Whole row read out through a register for the display latch
  always @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= {COLS{1'b0}};
    end else begin
      for (j = 0; j < COLS; j = j + 1) begin
        rd_data[j] <= mem[j][rd_row];
      end
    end
  end

endmodule

// ===== verification/lcdw_asserts.sv
`timescale 1ns/1ps
module lcdw_asserts (
  input wire       ref_clk, rst, mode_set, ptr_load, dev_select,
  input wire       data_valid, busy, byte_ack, byte_nack,
  input wire       strap_subaddr_bit0, strap_subaddr_bit1,
  input wire       strap_subaddr_bit2,
  input wire [1:0] mode_value, drive_mode,
  input wire [5:0] ptr_value, data_ptr,
  input wire [2:0] dev_value, sub_cnt
);
  // Command strobes win over a byte offered in the same cycle
  wire       take = data_valid & ~busy & ~mode_set & ~ptr_load & ~dev_select;
  wire       done = byte_ack | byte_nack;
  wire       four = take && drive_mode == 2'b00;
  wire [2:0] strap = {strap_subaddr_bit2, strap_subaddr_bit1,
                      strap_subaddr_bit0};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_STATIC_LAT: assert property (
    take && drive_mode == 2'b01 |-> ##9 done) else $error("static late");
  AST_FOUR_LAT: assert property (
    four |=> busy [*2] ##1 done) else $error("four late");
  AST_PTR_STEP: assert property (
    four && data_ptr < 6'd38 |-> ##3 data_ptr == $past(data_ptr, 3) + 6'd2)
    else $error("pointer step");
  AST_NO_MATCH: assert property (
    four && data_ptr < 6'd38 && sub_cnt != strap |-> ##3 byte_nack)
    else $error("nack missing");
  AST_SUB_WRAP: assert property (
    four && data_ptr == 6'd39 |-> ##3 sub_cnt == $past(sub_cnt, 3) + 3'd1)
    else $error("sub wrap");
  AST_PTR_LOAD: assert property (
    ptr_load && !busy |=> data_ptr == $past(ptr_value)) else $error("ptr");
  AST_DEV_LOAD: assert property (
    dev_select && !busy |=> sub_cnt == $past(dev_value)) else $error("dev");
  AST_MODE_LOAD: assert property (
    mode_set && !busy |=> drive_mode == $past(mode_value)) else $error("mode");
endmodule

bind lcdw_top lcdw_asserts lcdw_asserts_i (.ref_clk, .rst, .mode_set,
  .ptr_load, .dev_select, .data_valid, .busy, .byte_ack, .byte_nack,
  .strap_subaddr_bit0, .strap_subaddr_bit1, .strap_subaddr_bit2,
  .mode_value, .drive_mode, .ptr_value, .data_ptr, .dev_value, .sub_cnt);

// ===== verification/lcdw_host.sv
`timescale 1ns/1ps
module lcdw_host (
  input  wire       ref_clk,
  input  wire       byte_ack,
  input  wire       byte_nack,
  output reg  [2:0] cmd,
  output reg  [1:0] mode_value,
  output reg  [5:0] ptr_value,
  output reg  [2:0] dev_value,
  output reg  [2:0] bank,
  output reg        data_valid,
  output reg  [7:0] data_byte,
  output reg  [2:0] strap
);
  initial begin
    {cmd, mode_value, ptr_value, dev_value, bank} = 17'h0;
    {data_valid, data_byte} = 9'h0;
    strap = 3'h5;
  end
  task command(input [2:0] c, input [1:0] m, input [5:0] p, input [2:0] d);
    begin
      @(posedge ref_clk);
      cmd <= c;
      {mode_value, ptr_value, dev_value} <= {m, p, d};
      @(posedge ref_clk);
      cmd <= 3'h0;
    end
  endtask
  task banks(input i, input o);
    begin
      @(posedge ref_clk);
      bank <= {o, i, 1'b1};
      @(posedge ref_clk);
      bank <= 3'h0;
    end
  endtask
  // Released data lines carry the inverse so stale bytes cannot pass
  task put(input [7:0] b, output ok);
    integer n;
    begin
      @(posedge ref_clk);
      data_valid <= 1'b1;
      data_byte <= b;
      @(posedge ref_clk);
      data_valid <= 1'b0;
      data_byte <= ~b;
      #1;
      for (n = 0; n < 12 && !(byte_ack || byte_nack); n = n + 1)
        @(posedge ref_clk) #1;
      ok = byte_ack;
    end
  endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  reg         ref_clk, rst, ok, ib;
  wire [2:0]  cmd, dev_value, bank, strap, sub_cnt;
  wire [5:0]  ptr_value, data_ptr;
  wire [1:0]  mode_value, drive_mode;
  wire [7:0]  data_byte;
  wire [3:0]  bp;
  wire [39:0] seg;
  wire        data_valid, busy, byte_ack, byte_nack, ibk, obk;
  integer     num_errors, samples_checked, i, r;
  integer     cycles = 0;
  reg  [39:0] exp_row [0:3];
  reg  [1:0]  mode;
  reg  [5:0]  ptr;
  reg  [2:0]  sub;
  lcdw_top #(.ROW_HOLD(2)) lcdw_top_i (.ref_clk, .rst, .mode_set(cmd[0]),
    .mode_value, .ptr_load(cmd[1]), .ptr_value, .dev_select(cmd[2]),
    .dev_value, .bank_select(bank[0]), .bank_in_value(bank[1]),
    .bank_out_value(bank[2]), .data_valid, .data_byte,
    .strap_subaddr_bit0(strap[0]), .strap_subaddr_bit1(strap[1]),
    .strap_subaddr_bit2(strap[2]), .busy, .byte_ack, .byte_nack,
    .drive_mode, .data_ptr, .sub_cnt, .in_bank(ibk), .out_bank(obk),
    .backplane_out_0(bp[0]), .backplane_out_1(bp[1]),
    .backplane_out_2(bp[2]), .backplane_out_3(bp[3]),
    .segment_outputs(seg));
  lcdw_host lcdw_host_i (.ref_clk, .byte_ack, .byte_nack, .cmd, .mode_value,
    .ptr_value, .dev_value, .bank, .data_valid, .data_byte, .strap);
  task check(input [63:0] seen, input [63:0] want);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== want) begin
        num_errors = num_errors + 1;
        $display("BAD %0t %h %h", $time, seen, want);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (num_errors == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Pointer, subaddress and all three commands reloaded together
  task set(input [1:0] m, input [5:0] p, input [2:0] d);
    begin
      {mode, ptr, sub} = {m, p, d};
      lcdw_host_i.command(3'h7, m, p, d);
    end
  endtask
  task wr(input [7:0] b);
    integer n, w, j, k, s, base;
    begin
      n = mode == 2'b01 ? 8 : mode == 2'b10 ? 4 : mode == 2'b11 ? 3 : 2;
      w = mode == 2'b11 ? 3 : 8 / n;
      base = (ib && mode[0] != mode[1]) ? 2 : 0;
      s = 0;
      for (j = 0; j < n; j = j + 1) begin
        if (sub == strap) begin
          s = 1;
          for (k = 0; k < w && 7 - w * j - k >= 0; k = k + 1)
            exp_row[base + k][ptr] = b[7 - w * j - k];
        end
        ptr = ptr == 6'd39 ? 6'd0 : ptr + 6'd1;
        if (ptr == 6'd0)
          sub = sub + 3'd1;
      end
      lcdw_host_i.put(b, ok);
      check(ok, s);
      check(data_ptr, ptr);
      check(sub_cnt, sub);
    end
  endtask
  // Four-backplane mode shows every row; others would hide some
  task show;
    integer k;
    begin
      lcdw_host_i.command(3'h1, 2'b00, ptr, sub);
      repeat (12) @(posedge ref_clk);
      #1;
      for (r = 0; r < 4; r = r + 1) begin
        for (k = 0; k < 40 && bp[r] !== 1'b1; k = k + 1)
          @(posedge ref_clk) #1;
        check(seg, exp_row[r]);
      end
      lcdw_host_i.command(3'h1, mode, ptr, sub);
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  initial begin
    {rst, ib} = 2'b10;
    {num_errors, samples_checked} = 64'h0;
    for (r = 0; r < 4; r = r + 1)
      exp_row[r] = 40'h0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk) #1;
    check(drive_mode, 2'b00);
    set(2'b00, 6'd0, 3'd5);
    for (i = 0; i < 20; i = i + 1)
      wr(8'hff);
    for (i = 0; i < 4; i = i + 1) begin
      set(i[1:0] + 2'd1, 6'd3, 3'd5);
      wr(8'h96 ^ i[7:0]);
      show;
    end
    set(2'b01, 6'd10, 3'd5);
    lcdw_host_i.banks(1'b1, 1'b0);
    #1;
    check({ibk, obk}, 2'b10);
    ib = 1'b1;
    wr(8'h3c);
    set(2'b10, 6'd20, 3'd5);
    wr(8'hc3);
    show;
    ib = 1'b0;
    set(2'b01, 6'd0, 3'd5);
    lcdw_host_i.banks(1'b0, 1'b1);
    #1;
    check({ibk, obk}, 2'b01);
    repeat (12) @(posedge ref_clk);
    #1;
    check(bp, 4'h1);
    check(seg, exp_row[2]);
    set(2'b00, 6'd30, 3'd3);
    wr(8'h00);
    set(2'b01, 6'd38, 3'd4);
    wr(8'ha5);
    set(2'b00, 6'd39, 3'd5);
    wr(8'h5a);
    wr(8'h77);
    show;
    tally_and_finish;
  end
endmodule
